// File: design/iap_pkg.sv
// Package: register map, field layout, codes and timing for the flash programming control
package iap_pkg;
    // Register indices
    localparam logic [3:0] REG_MODE_CTRL = 4'h0;
    localparam logic [3:0] REG_RST_PAT   = 4'h1;
    localparam logic [3:0] REG_TIME_BUF  = 4'h2;
    localparam logic [3:0] REG_ADDR_LO   = 4'h3;
    localparam logic [3:0] REG_ADDR_HI   = 4'h4;
    localparam logic [3:0] REG_W0_LO     = 4'h5;
    localparam logic [3:0] REG_W0_HI     = 4'h6;
    localparam logic [3:0] REG_W3_HI     = 4'hC;

    // Mode control and timing/buffer register bit positions
    localparam int BIT_ENABLED = 7;
    localparam int BIT_MODE_HI = 6;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_UNLOCK  = 3;
    localparam int BIT_WR_INIT = 2;
    localparam int BIT_RD_EN   = 1;
    localparam int BIT_RD_INIT = 0;
    localparam int BIT_TSEL    = 1;
    localparam int BIT_BUF_CLR = 0;

    // Operation mode codes
    localparam logic [2:0] MODE_WRITE  = 3'h0;
    localparam logic [2:0] MODE_ERASE  = 3'h1;
    localparam logic [2:0] MODE_READ   = 3'h3;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;

    // Unlock pattern for words 1 to 3, chip reset value, last page word, unmapped read byte
    localparam logic [2:0][7:0] UNLOCK_LO = {8'hC3, 8'h0D, 8'h00};
    localparam logic [2:0][7:0] UNLOCK_HI = {8'h40, 8'h09, 8'h04};
    localparam logic [7:0]      CHIP_RST_VAL = 8'h55;
    localparam logic [4:0]      PAGE_LAST    = 5'h1F;
    localparam logic [7:0]      RST_BYTE     = 8'h00;

    // Timing
    localparam int SYS_PERIOD_NS  = 40;
    localparam int SUB_PERIOD_NS  = 31250;
    localparam int ERASE0_NS      = 3200000;
    localparam int WRITE0_NS      = 2200000;
    localparam int ERASE1_NS      = 3700000;
    localparam int WRITE1_NS      = 3000000;
    localparam int SUB_DIV_CYC    = SUB_PERIOD_NS / SYS_PERIOD_NS;
    localparam int ERASE0_TICKS   = (ERASE0_NS + SUB_PERIOD_NS - 1) / SUB_PERIOD_NS;
    localparam int WRITE0_TICKS   = (WRITE0_NS + SUB_PERIOD_NS - 1) / SUB_PERIOD_NS;
    localparam int ERASE1_TICKS   = (ERASE1_NS + SUB_PERIOD_NS - 1) / SUB_PERIOD_NS;
    localparam int WRITE1_TICKS   = (WRITE1_NS + SUB_PERIOD_NS - 1) / SUB_PERIOD_NS;
    localparam int UNLOCK_WIN_CYC = 1024;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ERASE = 3'b001,
        ST_PROG  = 3'b010,
        ST_READ  = 3'b011,
        ST_CLEAR = 3'b100
    } iap_state_t;
endpackage : iap_pkg

// File: design/iap_flash_ctrl.sv
// Flash in-application programming control and data registers
// How it works
// - Mode field: 000 write, 001 page erase, 011 read, 110 unlock; others reserved.
// - Erase or write never starts unless the enabled status is set.
// - Unlock trigger starts a window timer; hardware clears trigger on expiry.
// - Pattern: low bytes 00,0D,C3 and high bytes 04,09,40 for words 1 to 3.
// - Wrong pattern leaves erase/write disabled; correct pattern enables it.
// - Enabled status set only by hardware; software one ignored, zero disables.
// - Write-initiate starts erase or write per mode; cleared when finished.
// - Reads start only with read-enable set; clearing it blocks reads.
// - Read-initiate starts one word read; cleared when read completes.
// - Processor is stalled while an erase, write or read runs, not during a buffer clear.
// - Writing 55 to the chip reset register resets the whole chip.
// - Timing select 0: erase 3.2 ms, write 2.2 ms; 1: 3.7 ms, 3.0 ms.
// - Buffer-clear bit starts a buffer clear; cleared when clear completes.
// - Timing/buffer register bits 7 to 2 read zero.
// - Twelve-bit address: eight low bits plus low nibble; upper nibble reads zero.
// - Word 0 low byte write only updates that register.
// - Word 0 high byte write, with erase/write enabled, loads the word to buffer, then bumps address.
// - Address increment stops at page word 11111b, never wraps.
// - Words 1 to 3 each hold a 16-bit word as low and high byte.
module iap_flash_ctrl #(
    parameter int unsigned SUB_DIV      = iap_pkg::SUB_DIV_CYC,
    parameter int unsigned ERASE0_TICKS = iap_pkg::ERASE0_TICKS,
    parameter int unsigned WRITE0_TICKS = iap_pkg::WRITE0_TICKS,
    parameter int unsigned ERASE1_TICKS = iap_pkg::ERASE1_TICKS,
    parameter int unsigned WRITE1_TICKS = iap_pkg::WRITE1_TICKS,
    parameter int unsigned UNLOCK_CYC   = iap_pkg::UNLOCK_WIN_CYC,
    parameter int unsigned PAGE_WORDS   = 32
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_reg_we,
    input  wire logic        i_reg_re,
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_cpu_stall,
    output logic             o_chip_reset,
    output logic             o_fl_erase,
    output logic             o_fl_program,
    output logic             o_fl_rd,
    output logic      [11:0] o_fl_addr,
    output logic      [31:0] o_tag_mask,
    input  wire logic        i_fl_rvalid,
    input  wire logic [15:0] i_fl_rdata,
    input  wire logic [4:0]  i_wbuf_idx,
    output logic      [15:0] o_wbuf_data
);
    import iap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks
    if (PAGE_WORDS != 32) begin : g_chk_page
        $error("iap_flash_ctrl: write buffer depth must be 32 words");
    end
    if (SUB_DIV < 1 || SUB_DIV > 65535) begin : g_chk_div
        $error("iap_flash_ctrl: sub clock divider out of range");
    end
    if (UNLOCK_CYC < 1 || UNLOCK_CYC > 65535) begin : g_chk_win
        $error("iap_flash_ctrl: unlock window out of range");
    end
    if (ERASE0_TICKS < 1 || ERASE0_TICKS > 65535) begin : g_chk_erase0
        $error("iap_flash_ctrl: erase duration 0 out of range");
    end
    if (WRITE0_TICKS < 1 || WRITE0_TICKS > 65535) begin : g_chk_write0
        $error("iap_flash_ctrl: write duration 0 out of range");
    end
    if (ERASE1_TICKS < 1 || ERASE1_TICKS > 65535) begin : g_chk_erase1
        $error("iap_flash_ctrl: erase duration 1 out of range");
    end
    if (WRITE1_TICKS < 1 || WRITE1_TICKS > 65535) begin : g_chk_write1
        $error("iap_flash_ctrl: write duration 1 out of range");
    end

    localparam logic [15:0] DIV_LAST = 16'(SUB_DIV - 1);
    localparam logic [15:0] WIN_LAST = 16'(UNLOCK_CYC - 1);
    localparam logic [15:0] E0_LAST  = 16'(ERASE0_TICKS - 1);
    localparam logic [15:0] W0_LAST  = 16'(WRITE0_TICKS - 1);
    localparam logic [15:0] E1_LAST  = 16'(ERASE1_TICKS - 1);
    localparam logic [15:0] W1_LAST  = 16'(WRITE1_TICKS - 1);

    typedef struct packed {
        iap_state_t      st;
        logic [2:0]      mode;
        logic            enabled;
        logic            unlock_trig;
        logic            wr_init;
        logic            rd_en;
        logic            rd_init;
        logic            time_sel;
        logic            buf_clr;
        logic [7:0]      rst_pat;
        logic [11:0]     addr;
        logic [3:0][7:0] dlo;
        logic [3:0][7:0] dhi;
        logic [5:0]      seen;
        logic [15:0]     win_cnt;
        logic [15:0]     div_cnt;
        logic [15:0]     tick_cnt;
        logic [4:0]      clr_idx;
        logic [31:0]     tag;
        logic [7:0]      rdata;
        logic            chip_rst;
        logic            fl_rd;
        logic [15:0]     wbuf_out;
    } iap_regs_t;

    iap_regs_t   q;
    iap_regs_t   d;
    logic [15:0] wbuf_mem [PAGE_WORDS];
    logic        mem_we;
    logic [4:0]  mem_idx;
    logic [15:0] mem_wd;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic       wr;
        logic       sub_tick;
        logic       pat_ok;
        logic [3:0] widx;
        logic [1:0] wsel;
        logic [15:0] dur_last;
        logic       hw_en;
        logic       clr_req;

        d        = q;
        hw_en    = 1'b0;
        clr_req  = 1'b0;
        sub_tick = 1'b0;
        pat_ok   = 1'b0;
        dur_last = 16'h0000;
        mem_we   = 1'b0;
        mem_idx  = q.addr[4:0];
        mem_wd   = {q.dhi[0], q.dlo[0]};
        wr       = i_reg_we;
        widx     = i_reg_addr - REG_W0_LO;
        wsel     = widx[2:1];
        d.chip_rst = 1'b0;
        d.fl_rd    = 1'b0;
        d.wbuf_out = wbuf_mem[i_wbuf_idx];

        // Sub clock enable
        sub_tick  = (q.div_cnt == DIV_LAST);
        d.div_cnt = sub_tick ? 16'h0000 : q.div_cnt + 16'h0001;

        pat_ok = (q.seen == 6'h3F);
        for (int k = 0; k < 3; k++) begin
            if (q.dlo[k + 1] != UNLOCK_LO[k] || q.dhi[k + 1] != UNLOCK_HI[k]) begin
                pat_ok = 1'b0;
            end
        end

        // Unlock window timer
        if (q.unlock_trig) begin
            d.win_cnt = q.win_cnt + 16'h0001;
            if (q.win_cnt == WIN_LAST) begin
                d.unlock_trig = 1'b0;
                if (q.mode == MODE_UNLOCK && pat_ok) begin
                    d.enabled = 1'b1;
                    hw_en     = 1'b1;
                end
            end
        end

        // Register writes
        if (wr) begin
            case (i_reg_addr)
                REG_MODE_CTRL: begin
                    d.mode  = i_reg_wdata[BIT_MODE_HI:BIT_MODE_LO];
                    d.rd_en = i_reg_wdata[BIT_RD_EN];
                    if (!i_reg_wdata[BIT_ENABLED] && !hw_en) begin
                        d.enabled = 1'b0;
                    end
                    if (i_reg_wdata[BIT_UNLOCK] && !q.unlock_trig) begin
                        d.unlock_trig = 1'b1;
                        d.win_cnt     = 16'h0000;
                        d.seen        = 6'h00;
                    end
                    if (i_reg_wdata[BIT_WR_INIT] && q.enabled && i_reg_wdata[BIT_ENABLED] &&
                        q.st == ST_IDLE &&
                        (i_reg_wdata[BIT_MODE_HI:BIT_MODE_LO] == MODE_WRITE ||
                         i_reg_wdata[BIT_MODE_HI:BIT_MODE_LO] == MODE_ERASE)) begin
                        d.wr_init = 1'b1;
                    end
                    if (i_reg_wdata[BIT_RD_INIT] && i_reg_wdata[BIT_RD_EN] &&
                        !i_reg_wdata[BIT_WR_INIT] && q.st == ST_IDLE &&
                        i_reg_wdata[BIT_MODE_HI:BIT_MODE_LO] == MODE_READ) begin
                        d.rd_init = 1'b1;
                    end
                end
                REG_RST_PAT: begin
                    d.rst_pat  = i_reg_wdata;
                    d.chip_rst = (i_reg_wdata == CHIP_RST_VAL);
                end
                REG_TIME_BUF: begin
                    d.time_sel = i_reg_wdata[BIT_TSEL];
                    if (i_reg_wdata[BIT_BUF_CLR]) begin
                        d.buf_clr = 1'b1;
                        clr_req   = 1'b1;
                    end
                end
                REG_ADDR_LO: d.addr[7:0]  = i_reg_wdata;
                REG_ADDR_HI: d.addr[11:8] = i_reg_wdata[3:0];
                default: begin
                    if (i_reg_addr >= REG_W0_LO && i_reg_addr <= REG_W3_HI) begin
                        if (widx[0]) begin
                            d.dhi[wsel] = i_reg_wdata;
                        end else begin
                            d.dlo[wsel] = i_reg_wdata;
                        end
                        if (q.unlock_trig && wsel != 2'h0) begin
                            d.seen[{wsel - 2'h1, widx[0]}] = 1'b1;
                        end
                        if (i_reg_addr == REG_W0_HI && q.enabled) begin
                            mem_we  = 1'b1;
                            mem_wd  = {i_reg_wdata, q.dlo[0]};
                            d.tag[q.addr[4:0]] = 1'b1;
                            if (q.addr[4:0] != PAGE_LAST) begin
                                d.addr = q.addr + 12'h001;
                            end
                        end
                    end
                end
            endcase
        end

        // Register reads
        if (i_reg_re) begin
            case (i_reg_addr)
                REG_MODE_CTRL: d.rdata = {q.enabled, q.mode, q.unlock_trig, q.wr_init,
                                          q.rd_en, q.rd_init};
                REG_RST_PAT:   d.rdata = q.rst_pat;
                REG_TIME_BUF:  d.rdata = {6'h00, q.time_sel, q.buf_clr};
                REG_ADDR_LO:   d.rdata = q.addr[7:0];
                REG_ADDR_HI:   d.rdata = {4'h0, q.addr[11:8]};
                default: begin
                    if (i_reg_addr >= REG_W0_LO && i_reg_addr <= REG_W3_HI) begin
                        d.rdata = widx[0] ? q.dhi[wsel] : q.dlo[wsel];
                    end else begin
                        d.rdata = RST_BYTE;
                    end
                end
            endcase
        end

        // Operation sequencer
        dur_last = q.time_sel ? W1_LAST : W0_LAST;
        if (q.st == ST_ERASE) begin
            dur_last = q.time_sel ? E1_LAST : E0_LAST;
        end
        case (q.st)
            ST_IDLE: begin
                d.tick_cnt = 16'h0000;
                d.clr_idx  = 5'h00;
                if (q.wr_init && q.enabled && q.mode == MODE_ERASE) begin
                    d.st = ST_ERASE;
                end else if (q.wr_init && q.enabled && q.mode == MODE_WRITE) begin
                    d.st = ST_PROG;
                end else if (q.wr_init) begin
                    d.wr_init = 1'b0;
                end else if (q.rd_init && q.rd_en) begin
                    d.st    = ST_READ;
                    d.fl_rd = 1'b1;
                end else if (q.rd_init) begin
                    d.rd_init = 1'b0;
                end else if (q.buf_clr) begin
                    d.st = ST_CLEAR;
                end
            end
            ST_ERASE, ST_PROG: begin
                if (sub_tick) begin
                    d.tick_cnt = q.tick_cnt + 16'h0001;
                    if (q.tick_cnt == dur_last) begin
                        d.wr_init = 1'b0;
                        d.st      = ST_CLEAR;
                        d.clr_idx = 5'h00;
                    end
                end
            end
            ST_READ: begin
                if (!q.rd_en) begin
                    d.rd_init = 1'b0;
                    d.st      = ST_IDLE;
                end else if (i_fl_rvalid) begin
                    d.dlo[0]  = i_fl_rdata[7:0];
                    d.dhi[0]  = i_fl_rdata[15:8];
                    d.rd_init = 1'b0;
                    d.st      = ST_IDLE;
                end
            end
            ST_CLEAR: begin
                mem_we    = 1'b1;
                mem_idx   = q.clr_idx;
                mem_wd    = 16'h0000;
                d.clr_idx = q.clr_idx + 5'h01;
                if (q.clr_idx == PAGE_LAST) begin
                    d.buf_clr = clr_req;
                    d.tag     = 32'h0000_0000;
                    d.st      = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase

        if (!i_rst_n) begin
            d = '0;
            d.st = ST_IDLE;
            mem_we = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State registers and write buffer
    always_ff @(posedge i_sys_clk) begin
        q <= d;
    end

    always_ff @(posedge i_sys_clk) begin
        if (mem_we) begin
            wbuf_mem[mem_idx] <= mem_wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_reg_rdata  = q.rdata;
    assign o_chip_reset = q.chip_rst;
    assign o_cpu_stall  = (q.st == ST_ERASE) || (q.st == ST_PROG) || (q.st == ST_READ);
    assign o_fl_erase   = (q.st == ST_ERASE);
    assign o_fl_program = (q.st == ST_PROG);
    assign o_fl_rd      = q.fl_rd;
    assign o_fl_addr    = q.addr;
    assign o_tag_mask   = q.tag;
    assign o_wbuf_data  = q.wbuf_out;
endmodule : iap_flash_ctrl

// File: tb/iap_flash_ctrl_sva.sv
// Checker: port-level properties of the flash programming control
module iap_flash_ctrl_sva #(
    parameter int unsigned SUB_DIV      = 4,
    parameter int unsigned ERASE1_TICKS = 6
) (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic        i_reg_we,
    input wire logic        i_reg_re,
    input wire logic [3:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_cpu_stall,
    input wire logic        o_chip_reset,
    input wire logic        o_fl_erase,
    input wire logic        o_fl_program,
    input wire logic        o_fl_rd,
    input wire logic [11:0] o_fl_addr
);
    import iap_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    logic [15:0] op_cnt_q;
    logic [15:0] op_cnt_d;
    logic        busy;
    assign busy = o_fl_erase || o_fl_program;
    always_comb op_cnt_d = busy ? op_cnt_q + 16'h1 : 16'h0;
    always_ff @(posedge i_sys_clk) op_cnt_q <= !i_rst_n ? 16'h0 : op_cnt_d;
    sequence s_rst_wr;
        i_reg_we && i_reg_addr == REG_RST_PAT && i_reg_wdata == CHIP_RST_VAL;
    endsequence
    sequence s_w0hi_wr;
        i_reg_we && i_reg_addr == REG_W0_HI;
    endsequence
    sequence s_hold8(sig);
        sig [*8];
    endsequence
    a_chip_reset_gen: assert property (s_rst_wr |=> o_chip_reset)
        else $error("chip reset pulse missing");
    a_chip_reset_cause: assert property (o_chip_reset |-> $past(i_reg_we
        && i_reg_addr == REG_RST_PAT && i_reg_wdata == CHIP_RST_VAL))
        else $error("chip reset without pattern write");
    a_op_exclusive: assert property (!(o_fl_erase && o_fl_program))
        else $error("erase and program together");
    a_stall_op: assert property (busy |-> o_cpu_stall)
        else $error("no stall during erase or program");
    a_rd_single: assert property (o_fl_rd |=> !o_fl_rd)
        else $error("read pulse longer than one cycle");
    a_addr_saturate: assert property (s_w0hi_wr ##0 o_fl_addr[4:0] == PAGE_LAST
        |=> $stable(o_fl_addr))
        else $error("address left the page");
    a_addr_step: assert property (s_w0hi_wr
        |=> o_fl_addr == $past(o_fl_addr) + 12'h1 || $stable(o_fl_addr))
        else $error("bad address step");
    a_addr_lo_load: assert property (i_reg_we && i_reg_addr == REG_ADDR_LO
        |=> o_fl_addr[7:0] == $past(i_reg_wdata))
        else $error("address low not loaded");
    a_tb_upper_zero: assert property (i_reg_re && i_reg_addr == REG_TIME_BUF
        |=> o_reg_rdata[7:2] == 6'h00)
        else $error("unimplemented bits not zero");
    a_op_min_len: assert property ($rose(busy) |-> s_hold8(busy))
        else $error("operation too short");
    a_op_bounded: assert property (op_cnt_q <= SUB_DIV * (ERASE1_TICKS + 1))
        else $error("operation too long");
endmodule : iap_flash_ctrl_sva
bind iap_flash_ctrl iap_flash_ctrl_sva #(.SUB_DIV(SUB_DIV), .ERASE1_TICKS(ERASE1_TICKS)) u_sva (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_we(i_reg_we), .i_reg_re(i_reg_re),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_cpu_stall(o_cpu_stall), .o_chip_reset(o_chip_reset), .o_fl_erase(o_fl_erase),
    .o_fl_program(o_fl_program), .o_fl_rd(o_fl_rd), .o_fl_addr(o_fl_addr));

// File: tb/iap_flash_model.sv
// Flash array model: answers word reads and collects the write buffer
module iap_flash_model #(
    parameter int RD_LAT = 3
) (
    input  wire logic        i_clk,
    input  wire logic        i_rd,
    input  wire logic [11:0] i_addr,
    input  wire logic        i_program,
    input  wire logic [15:0] i_wbuf_data,
    output logic             o_rvalid,
    output logic      [15:0] o_rdata,
    output logic      [4:0]  o_wbuf_idx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] got [32];
    logic [4:0]  pidx = 5'h00;
    int          wait_n = 0;
    initial begin
        o_rvalid = 1'b0;
        o_rdata = 16'h0000;
        o_wbuf_idx = 5'h00;
    end
    always @(posedge i_clk) begin
        o_rvalid <= (wait_n == 1);
        // Idle data toggles so stale words never match
        o_rdata <= (wait_n == 1) ? {4'hA, i_addr} : ~o_rdata;
        wait_n <= i_rd ? RD_LAT : (wait_n > 0 ? wait_n - 1 : 0);
        // Sweep the buffer while a write runs
        o_wbuf_idx <= !i_program ? 5'h00 : (o_wbuf_idx == 5'h1F ? 5'h1F : o_wbuf_idx + 5'h01);
        pidx <= o_wbuf_idx;
        if (i_program) got[pidx] <= i_wbuf_data;
    end
endmodule : iap_flash_model

// File: tb/tb.sv
// Testbench: register-level scenarios for the flash programming control
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import iap_pkg::*;
    localparam int SD = 20;
    localparam int W0 = 3;
    localparam int E1 = 6;
    logic clk = 0, rst_n = 0, we = 0, re = 0, rv, stall, crst, ers, prg, read_initiate;
    logic [3:0]  ra = 4'h0;
    logic [7:0]  wd = 8'h00, rdat;
    logic [11:0] fa;
    logic [31:0] tags;
    logic [15:0] frdat, wbd;
    logic [4:0]  widx;
    int err_total = 0, cmp_count = 0, rd_seen = 0;
    always #20 clk = ~clk;
    always @(posedge clk) if (read_initiate === 1'b1) rd_seen++;
    iap_flash_ctrl #(.SUB_DIV(SD), .ERASE0_TICKS(4), .WRITE0_TICKS(W0), .ERASE1_TICKS(E1),
        .WRITE1_TICKS(5), .UNLOCK_CYC(32)) uut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_we(we), .i_reg_re(re), .i_reg_addr(ra),
        .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_cpu_stall(stall), .o_chip_reset(crst),
        .o_fl_erase(ers), .o_fl_program(prg), .o_fl_rd(read_initiate), .o_fl_addr(fa),
        .o_tag_mask(tags), .i_fl_rvalid(rv), .i_fl_rdata(frdat), .i_wbuf_idx(widx),
        .o_wbuf_data(wbd));
    iap_flash_model u_fl (.i_clk(clk), .i_rd(read_initiate), .i_addr(fa), .i_program(prg),
        .i_wbuf_data(wbd), .o_rvalid(rv), .o_rdata(frdat), .o_wbuf_idx(widx));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask : wr
    task automatic rdq(input logic [3:0] a);
        @(posedge clk);
        re <= 1'b1;
        ra <= a;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        #1;
    endtask : rdq
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        rdq(a);
        chk(rdat, exp);
    endtask : rd
    task automatic wait_clr(input logic [3:0] a, input int b);
        rdq(a);
        for (int n = 0; n < 300 && rdat[b] !== 1'b0; n++) rdq(a);
        chk(rdat[b], 1'b0);
    endtask : wait_clr
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
        wr(REG_ADDR_HI, 8'hFF);
        rd(REG_ADDR_HI, 8'h0F);
        wr(REG_ADDR_HI, 8'h00);
        wr(REG_TIME_BUF, 8'hFE);
        rd(REG_TIME_BUF, 8'h02);
        wr(REG_W0_LO, 8'h5A);
        chk(fa, 12'h000);
        wr(REG_MODE_CTRL, 8'h80);
        rd(REG_MODE_CTRL, 8'h00);
        wr(REG_RST_PAT, 8'h54);
        chk(crst, 1'b0);
        wr(REG_RST_PAT, CHIP_RST_VAL);
        chk(crst, 1'b1);
    endtask : t_regs
    task automatic t_unlock(input bit good);
        logic [7:0] pat [6];
        pat = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
        if (!good) pat[5] = 8'h41;
        wr(REG_MODE_CTRL, 8'h68);
        for (int i = 0; i < 6; i++) wr(4'h7 + i[3:0], pat[i]);
        rd(REG_W3_HI, pat[5]);
        rd(REG_MODE_CTRL, 8'h68);
        wait_clr(REG_MODE_CTRL, BIT_UNLOCK);
        rd(REG_MODE_CTRL, good ? 8'hE0 : 8'h60);
    endtask : t_unlock
    task automatic t_load();
        wr(REG_TIME_BUF, 8'h01);
        wait_clr(REG_TIME_BUF, BIT_BUF_CLR);
        chk(tags, 32'h0);
        wr(REG_ADDR_LO, 8'h3E);
        wr(REG_W0_LO, 8'h34);
        chk(fa, 12'h03E);
        chk(tags, 32'h0);
        wr(REG_W0_HI, 8'h12);
        chk(fa, 12'h03F);
        wr(REG_W0_HI, 8'h56);
        chk(fa, 12'h03F);
        chk(tags, 32'hC0000000);
    endtask : t_load
    task automatic t_op(input logic [7:0] mode, input logic [7:0] tsel, input int lo, hi);
        int n;
        wr(REG_TIME_BUF, tsel);
        wr(REG_MODE_CTRL, mode);
        for (n = 0; n < 10 && prg !== 1'b1 && ers !== 1'b1; n++) @(posedge clk) #1;
        chk(stall, 1'b1);
        for (n = 0; prg === 1'b1 || ers === 1'b1; n++) @(posedge clk) #1;
        chk(n >= lo && n <= hi, 1'b1);
        rd(REG_MODE_CTRL, mode & 8'hFB);
        repeat (40) @(posedge clk);
    endtask : t_op
    task automatic t_read();
        int base;
        base = rd_seen;
        wr(REG_MODE_CTRL, 8'hB1);
        repeat (6) @(posedge clk);
        rd(REG_MODE_CTRL, 8'hB0);
        chk(rd_seen - base, 0);
        wr(REG_MODE_CTRL, 8'hB3);
        wait_clr(REG_MODE_CTRL, BIT_RD_INIT);
        chk(rd_seen - base, 1);
        rd(REG_W0_LO, 8'h3F);
        rd(REG_W0_HI, 8'hA0);
    endtask : t_read
    task automatic conclude();
        $display("Comparisons %0d, errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_unlock(1'b0);
        t_unlock(1'b1);
        t_load();
        t_op(8'h84, 8'h00, (W0 - 1) * SD - 1, W0 * SD + 2);
        chk(u_fl.got[30], 16'h1234);
        chk(u_fl.got[31], 16'h5634);
        t_op(8'h94, 8'h02, (E1 - 1) * SD - 1, E1 * SD + 2);
        t_read();
        wr(REG_MODE_CTRL, 8'h00);
        wr(REG_MODE_CTRL, 8'h84);
        repeat (4) @(posedge clk) #1;
        chk(prg, 1'b0);
        rd(REG_MODE_CTRL, 8'h00);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end
endmodule : tb
